// ### hdl/sss_pkg.sv
// Constants shared by the serial strobe shifter design
package sss_pkg;
   localparam int unsigned SSS_PROC_CLK_HZ = 3000000;
   localparam int unsigned SSS_SCLK_HZ = 750000;
   localparam int unsigned SSS_DIV_RATIO = SSS_PROC_CLK_HZ / SSS_SCLK_HZ;
   localparam int unsigned SSS_DIV_W = 2;
   localparam logic [SSS_DIV_W-1:0] SSS_DIV_RST = 2'h0;
   localparam logic [SSS_DIV_W-1:0] SSS_DIV_LAST = SSS_DIV_W'(SSS_DIV_RATIO - 1);
   localparam logic [SSS_DIV_W-1:0] SSS_DIV_HALF = SSS_DIV_W'(SSS_DIV_RATIO / 2);
   localparam int unsigned SSS_BITS = 8;
   localparam logic [3:0] SSS_BITS_RST = 4'h0;
   localparam logic [3:0] SSS_BITS_LAST = 4'h7;
   localparam int unsigned SSS_STROBES = 11;
   localparam logic [3:0] SSS_STB_DAC_LOAD = 4'h1;
   localparam logic [3:0] SSS_STB_DISPLAY = 4'h6;
   localparam logic [3:0] SSS_STB_KEYPAD = 4'h7;
   localparam logic [3:0] SSS_STB_WHEEL = 4'hA;
   localparam logic [7:0] SSS_BYTE_RST = 8'h00;
   localparam logic [10:0] SSS_STB_RST = 11'h000;
   typedef enum logic [1:0] {
      SSS_IDLE = 2'b01,
      SSS_SHIFT = 2'b10
   } sss_state_e;
endpackage : sss_pkg

// ### hdl/sss_strobe_dec.sv
// Address to one-hot strobe decoder
module sss_strobe_dec
   import sss_pkg::*;
(
   input wire logic [3:0] addr_i,
   input wire logic en_i,
   output logic [sss_pkg::SSS_STROBES-1:0] onehot_o
);
   genvar g;
   generate
      for (g = 0; g < SSS_STROBES; g++) begin : g_dec
         // Codes 11..15 hit no output, so a stray address selects nobody
         assign onehot_o[g] = en_i && (addr_i == 4'(g));
      end
   endgenerate
endmodule : sss_strobe_dec

// ### hdl/sss_shifter.sv
// Serial strobe shifter: byte to MSB-first serial line with destination strobes
// Summary of operation
// - Serial clock is the 3 MHz processor clock divided by four, 750 kHz.
// - One shift clock drives the shifter and goes to every receiver.
// - A byte write starts a transfer; bits leave MSB first.
// - After eight bits the divider is cleared, clocking stops, transfer ends.
// - Four low address bits pick which strobe is asserted.
// - Each strobe enables exactly one destination; no other may capture.
// - Eleven strobes 0..10: 1 DAC load, 6 display, 7 keypad, 10 wheel reset.
// - Shifter and strobe generator have separate chip selects.
module sss_shifter
   import sss_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic shifter_select_i,
   input wire logic strobe_gen_select_i,
   input wire logic wr_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] data_i,
   output logic busy_o,
   output logic sclk_o,
   output logic sdata_o,
   output logic [sss_pkg::SSS_STROBES-1:0] strobe_o,
   output logic dac_load_strobe_o,
   output logic display_strobe_o,
   output logic keypad_latch_strobe_o,
   output logic wheel_counter_clear_o
);
   import sss_pkg::*;

   sss_state_e state_q, state_d;
   logic [SSS_DIV_W-1:0] div_q;
   logic [3:0] bits_q;
   logic [7:0] shreg_q;
   logic sclk_q;
   logic [SSS_STROBES-1:0] stb_q;

   // Writes only count with their own chip select
   wire byte_wr = wr_i && shifter_select_i && (state_q == SSS_IDLE);
   wire stb_wr = wr_i && strobe_gen_select_i && (state_q == SSS_IDLE);
   wire fall_tick = (state_q == SSS_SHIFT) && (div_q == SSS_DIV_LAST);
   wire rise_tick = (state_q == SSS_SHIFT) && (div_q == SSS_DIV_HALF - 2'h1);
   wire last_bit = fall_tick && (bits_q == SSS_BITS_LAST);
   wire [SSS_STROBES-1:0] stb_sel;

   sss_strobe_dec u_dec (
      .addr_i(addr_i),
      .en_i(stb_wr),
      .onehot_o(stb_sel)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         SSS_IDLE: begin
            if (byte_wr) begin
               state_d = SSS_SHIFT;
            end
         end
         SSS_SHIFT: begin
            if (last_bit) begin
               state_d = SSS_IDLE;
            end
         end
         default: state_d = SSS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_q <= SSS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Divide by four; held cleared outside a transfer so the line clock stops
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || state_q != SSS_SHIFT) begin
         div_q <= SSS_DIV_RST;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sclk_q <= 1'b0;
      end else if (rise_tick) begin
         sclk_q <= 1'b1;
      end else if (fall_tick || state_q != SSS_SHIFT) begin
         sclk_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         bits_q <= SSS_BITS_RST;
      end else if (byte_wr) begin
         bits_q <= SSS_BITS_RST;
      end else if (fall_tick) begin
         bits_q <= bits_q + 4'h1;
      end
   end

   // Data changes on the falling serial edge, receivers sample on the rising one
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         shreg_q <= SSS_BYTE_RST;
      end else if (byte_wr) begin
         shreg_q <= data_i;
      end else if (fall_tick) begin
         shreg_q <= {shreg_q[6:0], 1'b0};
      end
   end

   // A strobe may be picked before the byte write and holds until the end
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         stb_q <= SSS_STB_RST;
      end else if (stb_wr) begin
         stb_q <= stb_sel;
      end else if (last_bit) begin
         stb_q <= SSS_STB_RST;
      end
   end

   assign busy_o = (state_q == SSS_SHIFT);
   assign sclk_o = sclk_q;
   assign sdata_o = shreg_q[7];
   assign strobe_o = stb_q;
   assign dac_load_strobe_o = stb_q[SSS_STB_DAC_LOAD];
   assign display_strobe_o = stb_q[SSS_STB_DISPLAY];
   assign keypad_latch_strobe_o = stb_q[SSS_STB_KEYPAD];
   assign wheel_counter_clear_o = stb_q[SSS_STB_WHEEL];

   // Checks
   strobe_onehot_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $onehot0(strobe_o)) else $error("more than one strobe active");
   clk_period_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(sclk_o) |-> ##4 $rose(sclk_o) || !busy_o) else $error("serial clock period not four cycles");
   clk_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !busy_o |-> ##1 !sclk_o) else $error("serial clock runs while idle");
   xfer_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(busy_o) |-> busy_o [*8] ##25 !busy_o) else $error("transfer not 32 cycles");
   start_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (wr_i && shifter_select_i && !busy_o) |=> busy_o && sdata_o == $past(data_i[7]))
      else $error("write did not start transfer with MSB");
   strobe_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (busy_o && !last_bit) |=> strobe_o == $past(strobe_o)) else $error("strobe changed mid transfer");
   strobe_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      last_bit |=> strobe_o == SSS_STB_RST) else $error("strobe not released at end");
   strobe_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i == SSS_STB_DAC_LOAD) |=> dac_load_strobe_o) else $error("DAC load strobe not decoded");
   bit_order_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      fall_tick && !last_bit |=> sdata_o == $past(shreg_q[6])) else $error("bit order wrong");

   // Serial clock edges follow the divider phase
   sclk_high_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      rise_tick |=> sclk_o)
      else $error("serial clock did not rise");

   sclk_low_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      fall_tick |=> !sclk_o)
      else $error("serial clock did not fall");

   // Receivers see no edge while nothing is sent
   sclk_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !busy_o |-> !sclk_o)
      else $error("serial clock high while idle");

   div_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !busy_o |-> div_q == SSS_DIV_RST)
      else $error("divider running while idle");

   bits_range_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      busy_o |-> bits_q <= SSS_BITS_LAST)
      else $error("bit counter beyond last bit");

   busy_done_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      last_bit |=> !busy_o)
      else $error("transfer did not end after last bit");

   // A byte write during a transfer must not disturb the shifter
   shift_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (busy_o && !fall_tick) |=> shreg_q == $past(shreg_q))
      else $error("shifter changed between falling edges");

   sdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (busy_o && !fall_tick) |=> $stable(sdata_o))
      else $error("serial data moved off the falling edge");

   // Unused codes must leave every destination deaf
   addr_range_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i > 4'hA) |=> strobe_o == SSS_STB_RST)
      else $error("unused address raised a strobe");

   strobe_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i == 4'h0) |=> strobe_o == 11'h001)
      else $error("strobe zero not decoded");

   wheel_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i == SSS_STB_WHEEL) |=> wheel_counter_clear_o)
      else $error("wheel reset strobe not decoded");

   keypad_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i == SSS_STB_KEYPAD) |=> keypad_latch_strobe_o)
      else $error("keypad strobe not decoded");

   display_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (stb_wr && addr_i == SSS_STB_DISPLAY) |=> display_strobe_o)
      else $error("display strobe not decoded");

   // Both chip selects in one cycle: both accesses are taken
   both_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (wr_i && shifter_select_i && strobe_gen_select_i && !busy_o && addr_i <= 4'hA) |=> busy_o && strobe_o != SSS_STB_RST)
      else $error("simultaneous selects not both taken");
endmodule : sss_shifter

// ### tb/sss_rx_model.sv
// Receiving assembly on the shared serial line, one per strobe
module sss_rx_model (
   input wire logic sclk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic sdata_i,
   output logic [7:0] byte_o,
   output logic [4:0] cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Async clear because the shift clock stands still during reset
   always_ff @(posedge sclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         byte_o <= 8'h00;
         cnt_o <= 5'h00;
      end else if (en_i) begin
         byte_o <= {byte_o[6:0], sdata_i};
         cnt_o <= cnt_o + 5'h01;
      end
   end
endmodule : sss_rx_model

// ### tb/test_serial_strobe_shifter.sv
// Scenario bench for the serial strobe shifter
module test_serial_strobe_shifter;
   timeunit 1ns;
   timeprecision 1ps;
   import sss_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, sh = 1'b0, sg = 1'b0, wr = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] data = 8'h00;
   logic busy, sclk, sdata, dac, disp, kyb, whl;
   logic [SSS_STROBES-1:0] stb;
   logic [7:0] rx_byte [SSS_STROBES];
   logic [4:0] rx_cnt [SSS_STROBES];
   int num_errors = 0, total_checks = 0, cyc = 0;
   sss_shifter i_dut (.ref_clk_i(clk), .rstn_i(rstn), .shifter_select_i(sh), .strobe_gen_select_i(sg),
      .wr_i(wr), .addr_i(addr), .data_i(data), .busy_o(busy), .sclk_o(sclk), .sdata_o(sdata),
      .strobe_o(stb), .dac_load_strobe_o(dac), .display_strobe_o(disp), .keypad_latch_strobe_o(kyb),
      .wheel_counter_clear_o(whl));
   for (genvar g = 0; g < SSS_STROBES; g++) begin : g_rx
      sss_rx_model i_rx (.sclk_i(sclk), .rstn_i(rstn), .en_i(stb[g]), .sdata_i(sdata),
         .byte_o(rx_byte[g]), .cnt_o(rx_cnt[g]));
   end
   initial forever #10 clk = ~clk;
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Inverted data after the cycle so a stale bus value cannot pass
   task automatic wr_op(input logic s, input logic g, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {sh, sg, wr, addr, data} <= {s, g, 1'b1, a, d};
      @(posedge clk);
      {sh, sg, wr, data} <= {3'b000, ~d};
      #1;
   endtask : wr_op
   task automatic xfer(input int k, input logic [7:0] d);
      logic [10:0] exp;
      int n, r;
      logic prev;
      exp = (k < 11) ? (11'h001 << k) : 11'h000;
      wr_op(1'b0, 1'b1, 4'(k), 8'h3C);
      chk(stb, exp);
      chk({whl, kyb, disp, dac}, {k == 10, k == 7, k == 6, k == 1});
      chk(busy, 1'b0);
      wr_op(1'b1, 1'b0, 4'h0, d);
      chk({busy, sdata}, {1'b1, d[7]});
      n = 0;
      r = 0;
      prev = sclk;
      while (busy === 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
         if (sclk === 1'b1 && prev === 1'b0) r++;
         prev = sclk;
         if (n == 10) {sh, wr, data} <= {2'b11, ~d};
         if (n == 11) {sh, wr} <= 2'b00;
         if (n == 16) chk(stb, exp);
      end
      chk(n, 32);
      chk(r, 8);
      chk({stb, sclk}, 12'h000);
      if (k < 11) chk({rx_cnt[k], rx_byte[k]}, {5'h08, d});
   endtask : xfer
   initial begin
      repeat (12) @(posedge clk);
      #1;
      chk({busy, sclk, sdata, stb}, 14'h0000);
      rstn <= 1'b1;
      for (int k = 0; k < 13; k++) xfer(k, 8'hA5 ^ 8'(k * 19));
      for (int k = 0; k < SSS_STROBES; k++) chk(rx_cnt[k], 5'h08);
      end_of_test();
   end
endmodule : test_serial_strobe_shifter
